// ---- verilog/jbs_pkg.sv ----
/*
 * Constants, types and decode functions for the boundary-scan data registers
 * and instruction decoding of the test access port.
 * Assumes a single 100 MHz system clock that samples the test port pins.
 */
// Function
// - Bypass is one stage, cleared to zero at Capture-DR when selected.
// - Identification register is 32 bits: version, part, maker, constant one.
// - Version field counts silicon revisions from zero upward.
// - Part number field holds a fixed 16-bit component code.
// - Maker field holds a fixed 11-bit manufacturer code.
// - A one in the reset data register holds the core in reset.
// - After the reset register clears, core stays reset for the time-out.
// - Reset register drives core reset directly, with no update latch.
// - Instruction register is 4 bits wide, sixteen opcodes.
// - All shift registers move least significant bit first.
// - Opcode 0x0 selects the boundary chain of pin signals.
// - Under EXTEST latched outputs drive pins as soon as IR loads.
// - EXTEST captures pins, shifts chain, update applies chain to pins.
// - Opcode 0x1 selects identification register; it is the power-up default.
// - Opcode 0x2 samples pins and preloads latches without touching pins.
// - Opcode 0xC selects reset register and leaves the TAP unreset.
// - Opcode 0xF selects bypass: capture zero, then shift.
// - No HIGHZ; outside EXTEST, core reset instead tristates all port pins.
// - Port works only with enable fuse set and disable bit clear.
// - Scan relies on clk sampling the port pins; TCK must be far slower than clk.
// - Reset from reset register sets a flag; power-on or zero write clears.
package jbs_pkg;
    localparam int IR_W = 4;
    localparam int ID_W = 32;
    localparam logic [3:0] OP_EXTEST   = 4'h0;
    localparam logic [3:0] OP_IDCODE   = 4'h1;
    localparam logic [3:0] OP_SAMPLE   = 4'h2;
    localparam logic [3:0] OP_CORE_RST = 4'hc;
    localparam logic [3:0] OP_BYPASS   = 4'hf;
    localparam logic [3:0] IR_CAPTURE  = 4'h1;
    localparam int VER_LSB  = 28;
    localparam int PART_LSB = 12;
    localparam int MFR_LSB  = 1;
    localparam int CELLS    = 4;
    localparam int C_IN     = 0;
    localparam int C_DATA   = 1;
    localparam int C_CTRL   = 2;
    localparam int C_PUD    = 3;
    localparam int ADDR_W = 2;
    localparam int DATA_W = 8;
    localparam logic [1:0] CTRL_IDX = 2'h0;
    localparam logic [1:0] STAT_IDX = 2'h1;
    localparam int CTRL_DIS_BIT = 7;
    localparam int STAT_RST_BIT = 0;
    localparam int STAT_EN_BIT  = 1;
    localparam int STAT_FLAG_BIT = 4;
    localparam logic [2:0] TIMED_WIN = 3'h4;

    typedef enum logic [15:0] {
        TAP_TLR  = 16'h0001, TAP_RTI  = 16'h0002, TAP_SDS  = 16'h0004,
        TAP_CDR  = 16'h0008, TAP_SHDR = 16'h0010, TAP_E1DR = 16'h0020,
        TAP_PDR  = 16'h0040, TAP_E2DR = 16'h0080, TAP_UDR  = 16'h0100,
        TAP_SIS  = 16'h0200, TAP_CIR  = 16'h0400, TAP_SHIR = 16'h0800,
        TAP_E1IR = 16'h1000, TAP_PIR  = 16'h2000, TAP_E2IR = 16'h4000,
        TAP_UIR  = 16'h8000
    } jbs_tap_t;

    typedef enum logic [3:0] {
        DR_BSC = 4'h1,
        DR_ID  = 4'h2,
        DR_RST = 4'h4,
        DR_BYP = 4'h8
    } jbs_dr_t;

    function automatic jbs_dr_t dr_sel(input logic [3:0] op);
        jbs_dr_t d;
        d = DR_BYP;
        if (op == OP_BYPASS) d = DR_BYP;
        if (op == OP_EXTEST) d = DR_BSC;
        if (op == OP_SAMPLE) d = DR_BSC;
        if (op == OP_IDCODE) d = DR_ID;
        if (op == OP_CORE_RST) d = DR_RST;
        return d;
    endfunction
endpackage

// ---- verilog/jbs_sync_if.sv ----
/*
 * Carrier between the top and its pin sampler: raw pin levels in,
 * filtered levels out. Assumes both ends share the system clock.
 */
`timescale 1ns/1ps
interface jbs_sync_if #(parameter int W = 1);
    logic [W-1:0] raw;
    logic [W-1:0] clean;
    modport drv (output raw, input clean);
    modport syn (input raw, output clean);
endinterface // jbs_sync_if

// ---- verilog/jbs_sync.sv ----
/*
 * Three-stage sampler for pins from outside the clock domain.
 * Assumes raw levels may change at any time relative to clk.
 */
`timescale 1ns/1ps
module jbs_sync #(
    parameter int W = 1
) (
    input wire logic  clk,
    input wire logic  rst_n,
    jbs_sync_if.syn   sif
);
    logic [W-1:0] s1_r, s2_r, s3_r, clean_r;
    logic [W-1:0] clean_nxt;

    // A level counts only once the second and third stages agree.
    always_comb begin
        clean_nxt = (s2_r & s3_r) | (clean_r & (s2_r | s3_r));
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_r    <= '0;
            s2_r    <= '0;
            s3_r    <= '0;
            clean_r <= '0;
        end else begin
            s1_r    <= sif.raw;
            s2_r    <= s1_r;
            s3_r    <= s2_r;
            clean_r <= clean_nxt;
        end
    end

    assign sif.clean = clean_r;
endmodule // jbs_sync

// ---- verilog/jbs_tap_top.sv ----
/*
 * Test access port: TAP sequencing, 4-bit instruction register, bypass,
 * identification, core reset register and a pin boundary chain, plus the
 * control and status registers reached over a plain register port.
 * Assumes TCK is far slower than clk (at least four clk periods per phase).
 */
`timescale 1ns/1ps
module jbs_tap_top #(
    parameter int          NPIN            = 8,
    parameter logic [3:0]  VERSION         = 4'h0,
    // Arbitrary identity values.
    // fixed part code
    parameter logic [15:0] PART_NUM        = 16'h5a5a,
    parameter logic [10:0] MAKER_ID        = 11'h2aa,
    parameter int          RST_TIMEOUT_CYC = 64
) (
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    input  wire logic                        tck,
    input  wire logic                        tms,
    input  wire logic                        tdi,
    output logic                             tdo,
    output logic                             tdo_oe,
    input  wire logic                        test_port_enable_fuse,
    input  wire logic                        ext_rst_n,
    output logic                             core_rst_n,
    input  wire logic [NPIN-1:0]             pin_in,
    input  wire logic [NPIN-1:0]             core_out,
    input  wire logic [NPIN-1:0]             core_oe,
    input  wire logic [NPIN-1:0]             core_pud,
    output logic      [NPIN-1:0]             pin_out,
    output logic      [NPIN-1:0]             pin_oe,
    output logic      [NPIN-1:0]             pin_pud,
    input  wire logic [jbs_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [jbs_pkg::DATA_W-1:0]  reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [jbs_pkg::DATA_W-1:0]  reg_rdata
);
    localparam int SW   = 5 + NPIN;
    localparam int BS_W = jbs_pkg::CELLS * NPIN;
    localparam int TO_W = $clog2(RST_TIMEOUT_CYC + 1);
    localparam logic [TO_W-1:0] TO_LOAD = TO_W'(RST_TIMEOUT_CYC);

    localparam logic [31:0] ID_VALUE = {VERSION, PART_NUM, MAKER_ID, 1'b1};

    jbs_sync_if #(.W(SW)) sif ();

    jbs_sync #(.W(SW)) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .sif   (sif)
    );

    // One sampler for every pin keeps TMS and TDI aligned with the TCK edge.
    assign sif.raw = {pin_in, test_port_enable_fuse, ext_rst_n, tdi, tms, tck};

    logic            tck_c, tms_c, tdi_c, ext_rst_n_c, fuse_c;
    logic [NPIN-1:0] pin_c;
    assign tck_c       = sif.clean[0];
    assign tms_c       = sif.clean[1];
    assign tdi_c       = sif.clean[2];
    assign ext_rst_n_c = sif.clean[3];
    assign fuse_c      = sif.clean[4];
    assign pin_c       = sif.clean[SW-1:5];

    function automatic jbs_pkg::jbs_tap_t tap_next(input jbs_pkg::jbs_tap_t s,
                                                  input logic m);
        jbs_pkg::jbs_tap_t n;
        n = jbs_pkg::TAP_TLR;
        unique case (s)
            jbs_pkg::TAP_TLR:  n = m ? jbs_pkg::TAP_TLR  : jbs_pkg::TAP_RTI;
            jbs_pkg::TAP_RTI:  n = m ? jbs_pkg::TAP_SDS  : jbs_pkg::TAP_RTI;
            jbs_pkg::TAP_SDS:  n = m ? jbs_pkg::TAP_SIS  : jbs_pkg::TAP_CDR;
            jbs_pkg::TAP_CDR:  n = m ? jbs_pkg::TAP_E1DR : jbs_pkg::TAP_SHDR;
            jbs_pkg::TAP_SHDR: n = m ? jbs_pkg::TAP_E1DR : jbs_pkg::TAP_SHDR;
            jbs_pkg::TAP_E1DR: n = m ? jbs_pkg::TAP_UDR  : jbs_pkg::TAP_PDR;
            jbs_pkg::TAP_PDR:  n = m ? jbs_pkg::TAP_E2DR : jbs_pkg::TAP_PDR;
            jbs_pkg::TAP_E2DR: n = m ? jbs_pkg::TAP_UDR  : jbs_pkg::TAP_SHDR;
            jbs_pkg::TAP_UDR:  n = m ? jbs_pkg::TAP_SDS  : jbs_pkg::TAP_RTI;
            jbs_pkg::TAP_SIS:  n = m ? jbs_pkg::TAP_TLR  : jbs_pkg::TAP_CIR;
            jbs_pkg::TAP_CIR:  n = m ? jbs_pkg::TAP_E1IR : jbs_pkg::TAP_SHIR;
            jbs_pkg::TAP_SHIR: n = m ? jbs_pkg::TAP_E1IR : jbs_pkg::TAP_SHIR;
            jbs_pkg::TAP_E1IR: n = m ? jbs_pkg::TAP_UIR  : jbs_pkg::TAP_PIR;
            jbs_pkg::TAP_PIR:  n = m ? jbs_pkg::TAP_E2IR : jbs_pkg::TAP_PIR;
            jbs_pkg::TAP_E2IR: n = m ? jbs_pkg::TAP_UIR  : jbs_pkg::TAP_SHIR;
            jbs_pkg::TAP_UIR:  n = m ? jbs_pkg::TAP_SDS  : jbs_pkg::TAP_RTI;
            default:           n = jbs_pkg::TAP_TLR;
        endcase
        return n;
    endfunction

    // Software-side state.
    logic                        dis_r, dis_nxt;
    logic                        pend_val_r, pend_val_nxt;
    logic [2:0]                  pend_cnt_r, pend_cnt_nxt;
    logic                        flag_r, flag_nxt;
    logic [jbs_pkg::DATA_W-1:0]  rdata_r, rdata_nxt;

    // Scan-side state.
    jbs_pkg::jbs_tap_t           tap_r, tap_nxt;
    logic                        tck_q_r;
    logic [3:0]                  ir_r, ir_nxt;
    logic [3:0]                  ir_sh_r, ir_sh_nxt;
    logic                        byp_r, byp_nxt;
    logic [31:0]                 id_sh_r, id_sh_nxt;
    logic                        rst_dr_r, rst_dr_nxt;
    logic [BS_W-1:0]             bs_sh_r, bs_sh_nxt;
    logic [BS_W-1:0]             bs_upd_r, bs_upd_nxt;
    logic                        tdo_r, tdo_nxt;
    logic                        tdo_oe_r, tdo_oe_nxt;

    // Core reset and pin state.
    logic [TO_W-1:0]             to_cnt_r, to_cnt_nxt;
    logic [NPIN-1:0]             pout_r, pout_nxt;
    logic [NPIN-1:0]             poe_r, poe_nxt;
    logic [NPIN-1:0]             ppud_r, ppud_nxt;

    logic                        port_en, tck_rise, tck_fall;
    jbs_pkg::jbs_dr_t            sel;

    assign port_en  = fuse_c & ~dis_r;
    // Each TCK level must last two clk periods, or an edge is missed.
    // edges found from sampled TCK
    assign tck_rise = tck_c & ~tck_q_r;
    assign tck_fall = ~tck_c & tck_q_r;
    assign sel      = jbs_pkg::dr_sel(ir_r);

    always_comb begin
        tap_nxt    = tap_r;
        ir_nxt     = ir_r;
        ir_sh_nxt  = ir_sh_r;
        byp_nxt    = byp_r;
        id_sh_nxt  = id_sh_r;
        rst_dr_nxt = rst_dr_r;
        bs_sh_nxt  = bs_sh_r;
        bs_upd_nxt = bs_upd_r;
        tdo_nxt    = tdo_r;
        tdo_oe_nxt = tdo_oe_r;
        if (!port_en) begin
            tap_nxt    = jbs_pkg::TAP_TLR;
            ir_nxt     = jbs_pkg::OP_IDCODE;
            tdo_oe_nxt = 1'b0;
        end else if (tck_rise) begin
            tap_nxt = tap_next(tap_r, tms_c);
            unique case (tap_r)
                jbs_pkg::TAP_TLR: ir_nxt = jbs_pkg::OP_IDCODE;
                jbs_pkg::TAP_CIR: ir_sh_nxt = jbs_pkg::IR_CAPTURE;
                jbs_pkg::TAP_SHIR: ir_sh_nxt = {tdi_c, ir_sh_r[3:1]};
                jbs_pkg::TAP_UIR: ir_nxt = ir_sh_r;
                jbs_pkg::TAP_CDR: begin
                    if (sel == jbs_pkg::DR_BYP) byp_nxt = 1'b0;
                    if (sel == jbs_pkg::DR_ID) id_sh_nxt = ID_VALUE;
                    if (sel == jbs_pkg::DR_BSC) begin
                        for (int i = 0; i < NPIN; i++) begin
                            bs_sh_nxt[i*jbs_pkg::CELLS + jbs_pkg::C_IN]   = pin_c[i];
                            bs_sh_nxt[i*jbs_pkg::CELLS + jbs_pkg::C_DATA] = core_out[i];
                            bs_sh_nxt[i*jbs_pkg::CELLS + jbs_pkg::C_CTRL] = core_oe[i];
                            bs_sh_nxt[i*jbs_pkg::CELLS + jbs_pkg::C_PUD]  = core_pud[i];
                        end
                    end
                end
                jbs_pkg::TAP_SHDR: begin
                    // shift in at the top, out at bit zero
                    unique case (sel)
                        jbs_pkg::DR_BYP: byp_nxt = tdi_c;
                        jbs_pkg::DR_ID:  id_sh_nxt = {tdi_c, id_sh_r[31:1]};
                        jbs_pkg::DR_RST: rst_dr_nxt = tdi_c;
                        jbs_pkg::DR_BSC: bs_sh_nxt = {tdi_c, bs_sh_r[BS_W-1:1]};
                    endcase
                end
                jbs_pkg::TAP_UDR: begin
                    // update loads latches for both chain opcodes
                    if (sel == jbs_pkg::DR_BSC) bs_upd_nxt = bs_sh_r;
                end
                default: ;
            endcase
        end else if (tck_fall) begin
            // Moving TDO on the fall gives the controller a settled bit by the middle of the high phase.
            // least significant bit leaves first
            tdo_oe_nxt = (tap_r == jbs_pkg::TAP_SHDR) || (tap_r == jbs_pkg::TAP_SHIR);
            if (tap_r == jbs_pkg::TAP_SHIR) begin
                tdo_nxt = ir_sh_r[0];
            end else begin
                unique case (sel)
                    jbs_pkg::DR_BYP: tdo_nxt = byp_r;
                    jbs_pkg::DR_ID:  tdo_nxt = id_sh_r[0];
                    jbs_pkg::DR_RST: tdo_nxt = rst_dr_r;
                    jbs_pkg::DR_BSC: tdo_nxt = bs_sh_r[0];
                endcase
            end
        end
    end

    // The reset cell is cleared only by power-on reset or by shifting a zero in; Test-Logic-Reset leaves it.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tap_r    <= jbs_pkg::TAP_TLR;
            tck_q_r  <= 1'b0;
            ir_r     <= jbs_pkg::OP_IDCODE;
            ir_sh_r  <= '0;
            byp_r    <= 1'b0;
            id_sh_r  <= '0;
            rst_dr_r <= 1'b0;
            bs_sh_r  <= '0;
            bs_upd_r <= '0;
            tdo_r    <= 1'b0;
            tdo_oe_r <= 1'b0;
        end else begin
            tap_r    <= tap_nxt;
            tck_q_r  <= tck_c;
            ir_r     <= ir_nxt;
            ir_sh_r  <= ir_sh_nxt;
            byp_r    <= byp_nxt;
            id_sh_r  <= id_sh_nxt;
            rst_dr_r <= rst_dr_nxt;
            bs_sh_r  <= bs_sh_nxt;
            bs_upd_r <= bs_upd_nxt;
            tdo_r    <= tdo_nxt;
            tdo_oe_r <= tdo_oe_nxt;
        end
    end

    assign tdo    = tdo_r;
    assign tdo_oe = tdo_oe_r;

    logic rst_src, extest;
    // reset register acts like the reset pin
    assign rst_src = rst_dr_r | ~ext_rst_n_c;
    assign extest  = port_en && (ir_r == jbs_pkg::OP_EXTEST);

    always_comb begin
        to_cnt_nxt = to_cnt_r;
        // The count reloads while any source holds reset, so only the last release counts.
        // hold reset for the time-out
        if (rst_src) begin
            to_cnt_nxt = TO_LOAD;
        end else if (to_cnt_r != '0) begin
            to_cnt_nxt = to_cnt_r - TO_W'(1);
        end
        // Under EXTEST the latches own the pins, even while the core is held in reset.
        for (int i = 0; i < NPIN; i++) begin
            if (extest) begin
                pout_nxt[i] = bs_upd_r[i*jbs_pkg::CELLS + jbs_pkg::C_DATA];
                poe_nxt[i]  = bs_upd_r[i*jbs_pkg::CELLS + jbs_pkg::C_CTRL];
                ppud_nxt[i] = bs_upd_r[i*jbs_pkg::CELLS + jbs_pkg::C_PUD];
            end else begin
                pout_nxt[i] = core_out[i];
                poe_nxt[i]  = core_oe[i] & core_rst_n;
                ppud_nxt[i] = core_pud[i] | ~core_rst_n;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            to_cnt_r <= '0;
            pout_r   <= '0;
            poe_r    <= '0;
            ppud_r   <= '0;
        end else begin
            to_cnt_r <= to_cnt_nxt;
            pout_r   <= pout_nxt;
            poe_r    <= poe_nxt;
            ppud_r   <= ppud_nxt;
        end
    end

    // Core reset is combinational, so it asserts in the cycle the cell takes a one.
    // no latch between cell and core reset
    assign core_rst_n = rst_n & ~rst_src & (to_cnt_r == '0);
    assign pin_out    = pout_r;
    assign pin_oe     = poe_r;
    assign pin_pud    = ppud_r;

    // The disable bit changes only when the same value is written twice
    // within the timed window, so a stray write cannot lock out the port.
    always_comb begin
        dis_nxt      = dis_r;
        pend_val_nxt = pend_val_r;
        pend_cnt_nxt = (pend_cnt_r != 3'h0) ? pend_cnt_r - 3'h1 : 3'h0;
        flag_nxt     = flag_r;
        // Read data stand for one cycle only; idle cycles return zero.
        rdata_nxt    = '0;
        if (reg_wr && reg_addr == jbs_pkg::CTRL_IDX) begin
            if (pend_cnt_r != 3'h0 && reg_wdata[jbs_pkg::CTRL_DIS_BIT] == pend_val_r) begin
                dis_nxt      = pend_val_r;
                pend_cnt_nxt = 3'h0;
            end else begin
                pend_val_nxt = reg_wdata[jbs_pkg::CTRL_DIS_BIT];
                pend_cnt_nxt = jbs_pkg::TIMED_WIN;
            end
        end
        if (reg_wr && reg_addr == jbs_pkg::STAT_IDX && !reg_wdata[jbs_pkg::STAT_FLAG_BIT]) begin
            flag_nxt = 1'b0;
        end
        if (rst_dr_r) flag_nxt = 1'b1;
        if (reg_rd) begin
            unique case (reg_addr)
                jbs_pkg::CTRL_IDX: rdata_nxt[jbs_pkg::CTRL_DIS_BIT] = dis_r;
                jbs_pkg::STAT_IDX: begin
                    rdata_nxt[jbs_pkg::STAT_RST_BIT]  = ~core_rst_n;
                    rdata_nxt[jbs_pkg::STAT_EN_BIT]   = port_en;
                    rdata_nxt[jbs_pkg::STAT_FLAG_BIT] = flag_r;
                end
                default: rdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dis_r      <= 1'b0;
            pend_val_r <= 1'b0;
            pend_cnt_r <= 3'h0;
            flag_r     <= 1'b0;
            rdata_r    <= '0;
        end else begin
            dis_r      <= dis_nxt;
            pend_val_r <= pend_val_nxt;
            pend_cnt_r <= pend_cnt_nxt;
            flag_r     <= flag_nxt;
            rdata_r    <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;
endmodule // jbs_tap_top

// ---- sim/jbs_jtag_ctl.sv ----
/*
 * Model of the external scan controller: drives tck, tms, tdi, samples tdo.
 * Assumes the device samples tck with its own clock; tck idles low.
 */
`timescale 1ns/1ps
module jbs_jtag_ctl (
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo,
    input  wire logic tdo_oe
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // Tdo is read halfway through the high phase, since the device updates it some clocks after the fall.
    task automatic step(input logic m, input logic d, output logic o);
        tck = 1'b0;
        tms = m;
        tdi = d;
        #40 tck = 1'b1;
        // A released pin reads as the inverse, so a missing output enable is caught.
        #20 o = tdo_oe ? tdo : ~tdo;
        #20;
    endtask

    task automatic tap_reset();
        logic o;
        #3;
        repeat (5) step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
        #40 tck = 1'b0;
    endtask

    task automatic scan(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        logic o;
        dout = 32'h0;
        #3 step(1'b1, 1'b0, o);
        if (ir) step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
        step(1'b0, 1'b0, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
        #40 tck = 1'b0;
    endtask
endmodule // jbs_jtag_ctl

// ---- sim/jbs_tap_chk.sv ----
/*
 * Concurrent checks on the pins of the scan port top module.
 * Assumes it is bound into every instance of that module.
 */
`timescale 1ns/1ps
module jbs_tap_chk #(
    parameter int NPIN            = 8,
    parameter int RST_TIMEOUT_CYC = 64
) (
    input wire logic                       clk,
    input wire logic                       rst_n,
    input wire logic                       tck,
    input wire logic                       tdo,
    input wire logic                       tdo_oe,
    input wire logic                       test_port_enable_fuse,
    input wire logic                       ext_rst_n,
    input wire logic                       core_rst_n,
    input wire logic [NPIN-1:0]            pin_oe,
    input wire logic [jbs_pkg::ADDR_W-1:0] reg_addr,
    input wire logic                       reg_rd,
    input wire logic [jbs_pkg::DATA_W-1:0] reg_rdata
);
    int low_cnt;
    always_ff @(posedge clk) begin
        if (!rst_n || core_rst_n) low_cnt <= 0;
        else if (low_cnt < 100000) low_cnt <= low_cnt + 1;
    end

    a_rst_outs: assert property (@(posedge clk) !rst_n |=>
        !tdo && !tdo_oe && pin_oe == '0 && reg_rdata == 8'h00)
        else $error("outputs not cleared by reset");
    a_rst_core: assert property (@(posedge clk) !rst_n |-> !core_rst_n)
        else $error("core left running during reset");
    a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n)
        !reg_rd |=> reg_rdata == 8'h00) else $error("read data outside read slot");
    a_unmapped_zero: assert property (@(posedge clk) disable iff (!rst_n)
        reg_rd && reg_addr > 2'h1 |=> reg_rdata == 8'h00) else $error("unmapped read");
    a_ext_reset: assert property (@(posedge clk) disable iff (!rst_n)
        !ext_rst_n [*6] |-> !core_rst_n) else $error("pin reset ignored");
    a_reset_timeout: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(core_rst_n) |-> low_cnt >= RST_TIMEOUT_CYC) else $error("time-out short");
    a_port_off: assert property (@(posedge clk) disable iff (!rst_n)
        !test_port_enable_fuse [*8] |-> !tdo_oe) else $error("port drives while fused off");
    a_tdo_on_fall: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(tdo) |-> !$past(tck, 2)) else $error("tdo moved outside low phase");
endmodule // jbs_tap_chk

bind jbs_tap_top jbs_tap_chk #(.NPIN(NPIN), .RST_TIMEOUT_CYC(RST_TIMEOUT_CYC)) chk (
    .clk, .rst_n, .tck, .tdo, .tdo_oe, .test_port_enable_fuse, .ext_rst_n,
    .core_rst_n, .pin_oe, .reg_addr, .reg_rd, .reg_rdata);

// ---- sim/testbench.sv ----
/*
 * Self-checking bench for the scan port top module.
 * Assumes the controller model and the bound checker are compiled alongside.
 */
`timescale 1ns/1ps
module testbench;
    localparam logic [3:0]  VER  = 4'h1;
    // Arbitrary identity values.
    localparam logic [15:0] PART = 16'h1234;
    localparam logic [10:0] MAKR = 11'h055;
    localparam logic [31:0] ID   = {VER, PART, MAKR, 1'b1};
    localparam logic [31:0] PINS = 32'h10100101;
    typedef struct { logic [3:0] op; int n; logic [31:0] din, exp, msk; } jbs_row_t;
    logic       clk, rst_n, tck, tms, tdi, tdo, tdo_oe, fuse, ext_rst_n, core_rst_n;
    logic [7:0] pin_in, core_out, core_oe, core_pud, pin_out, pin_oe, pin_pud;
    logic [7:0] reg_wdata, reg_rdata;
    logic [1:0] reg_addr;
    logic       reg_wr, reg_rd;
    logic [31:0] q;
    int         errors = 0;
    int         cmp_count = 0;
    jbs_row_t   rows [5] = '{'{4'h1, 32, 32'h0, ID, 32'hffffffff},
        '{4'hf, 2, 32'h3, 32'h2, 32'h3}, '{4'h5, 2, 32'h3, 32'h2, 32'h3},
        '{4'h3, 2, 32'h3, 32'h2, 32'h3}, '{4'h2, 32, 32'h44666644, PINS, 32'h11111111}};

    jbs_jtag_ctl ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
    jbs_tap_top #(.VERSION(VER), .PART_NUM(PART), .MAKER_ID(MAKR), .RST_TIMEOUT_CYC(40)) dut (
        .clk, .rst_n, .tck, .tms, .tdi, .tdo, .tdo_oe, .test_port_enable_fuse(fuse),
        .ext_rst_n, .core_rst_n, .pin_in, .core_out, .core_oe, .core_pud, .pin_out,
        .pin_oe, .pin_pud, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] a, input logic [7:0] m, input logic [7:0] e,
                      input string nm);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(nm, reg_rdata & m, e);
    endtask

    task automatic wait_core();
        int k;
        k = 0;
        while (core_rst_n !== 1'b1 && k < 200) begin
            @(posedge clk);
            k++;
        end
        if (k >= 200) begin
            chk("core release wait", 32'h0, 32'h1);
            give_verdict();
        end
    endtask

    initial begin
        #500000;
        chk("watchdog", 32'h0, 32'h1);
        give_verdict();
    end

    initial begin
        rst_n = 1'b0;
        fuse = 1'b1;
        ext_rst_n = 1'b1;
        pin_in = 8'ha5;
        core_out = 8'h0f;
        core_oe = 8'hf0;
        core_pud = 8'h55;
        reg_addr = 2'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        wait_core();
        ctl.tap_reset();
        ctl.scan(1'b0, 32, 32'h0, q);
        chk("idcode", q, ID);
        foreach (rows[i]) begin
            ctl.scan(1'b1, 4, {28'h0, rows[i].op}, q);
            chk("ir capture", q, 32'h1);
            ctl.scan(1'b0, rows[i].n, rows[i].din, q);
            chk("dr out", q & rows[i].msk, rows[i].exp);
        end
        chk("sample pins", {pin_out, pin_oe, pin_pud}, {core_out, core_oe, core_pud});
        ctl.scan(1'b1, 4, 32'h0, q);
        chk("extest load", {pin_out, pin_oe, pin_pud}, 24'h3cff00);
        ctl.scan(1'b0, 32, 32'heeccccee, q);
        chk("extest capture", q & 32'h11111111, PINS);
        chk("extest update", {pin_out, pin_oe, pin_pud}, 24'hc3ffff);
        ctl.scan(1'b1, 4, 32'hc, q);
        ctl.scan(1'b0, 1, 32'h1, q);
        chk("core reset", {core_rst_n, pin_oe}, 9'h000);
        rd(2'h1, 8'h13, 8'h13, "status in reset");
        ctl.scan(1'b0, 1, 32'h0, q);
        chk("reset cell", q, 32'h1);
        chk("reset hold", core_rst_n, 1'b0);
        wait_core();
        rd(2'h1, 8'h11, 8'h10, "flag sticky");
        wr(2'h1, 8'h00);
        rd(2'h1, 8'h10, 8'h00, "flag clear");
        @(posedge clk) ext_rst_n <= 1'b0;
        repeat (10) @(posedge clk);
        #1 chk("pin reset", core_rst_n, 1'b0);
        @(posedge clk);
        ext_rst_n <= 1'b1;
        wait_core();
        wr(2'h0, 8'h80);
        wr(2'h0, 8'h80);
        rd(2'h1, 8'h02, 8'h00, "port disabled");
        wr(2'h0, 8'h00);
        rd(2'h1, 8'h02, 8'h00, "single write");
        repeat (8) @(posedge clk);
        wr(2'h0, 8'h00);
        wr(2'h0, 8'h00);
        rd(2'h1, 8'h02, 8'h02, "port enabled");
        @(posedge clk) fuse <= 1'b0;
        repeat (10) @(posedge clk);
        rd(2'h1, 8'h02, 8'h00, "fuse off");
        @(posedge clk) fuse <= 1'b1;
        wr(2'h2, 8'hff);
        rd(2'h2, 8'hff, 8'h00, "unmapped write");
        rd(2'h3, 8'hff, 8'h00, "unmapped read");
        give_verdict();
    end
endmodule // testbench
